// ==== pkg/bdh_pkg.sv ====
// Constants and types for the backplane DMA / halt / power-fail control block.
// Assumes a single 50 MHz clock and a synchronous active-high reset.
// Contract
// RL1: DMA option holds bus request low until it receives the grant.
// RL2: Processor grants only when its bus cycle ended and sync not driven.
// RL3: Granted device drops request and asserts select-acknowledge as master.
// RL4: Grant withdrawn on acknowledge; processor waits for acknowledge release.
// RL5: Halt request valid after 25 us continuous assertion; then halt.
// RL6: While halted ignore interrupts, keep DMA arbitration, run debug microcode.
// RL7: Refresh line refreshes memories on each sync plus data-in transaction.
// RL8: Masters avoid long bursts; full refresh at least every 1.6 ms.
// RL9: Loss of AC power-good while running starts the power-fail trap.
// RL10: Extended lines carry address 21:18 in address phase, undefined in data.
`default_nettype none
package bdh_pkg;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_MHZ = 50;
    localparam int HALT_MIN_US = 25;
    localparam int HALT_CYCLES = HALT_MIN_US * CLK_MHZ; // Least time, exact
    localparam int HALT_CNT_W = 11;
    localparam int SYNC_STAGES = 3;
    localparam int EXT_ADDR_LO = 18;
    localparam int EXT_ADDR_W = 4;
    localparam logic [3:0] EXT_ADDR_RST = 4'h0;

    // ****************************************
    // Arbiter states
    // ****************************************
    typedef enum logic [3:0] {
        ARB_CPU = 4'b0001,  // Processor owns bus
        ARB_WAIT = 4'b0010, // Request seen, cycle draining
        ARB_GRANT = 4'b0100, // Grant driven
        ARB_DMA = 4'b1000   // DMA device is master
    } bdh_arb_t;
endpackage
`default_nettype wire

// ==== pkg/bdh_sync_if.sv ====
// Carrier for the synchronised backplane inputs between sync stage and core.
// Assumes one clock domain on both sides.
`default_nettype none
interface bdh_sync_if;
    logic dma_req;
    logic sack;
    logic halt;
    logic pwr_ok;
    modport src (output dma_req, output sack, output halt, output pwr_ok);
    modport dst (input dma_req, input sack, input halt, input pwr_ok);
endinterface
`default_nettype wire

// ==== rtl/bdh_in_sync.sv ====
// Three-stage synchroniser for the asynchronous backplane inputs.
// Assumes inputs are active-high here; a change is taken when stages two and three agree.
`default_nettype none
module bdh_in_sync (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic [3:0] i_raw,
    bdh_sync_if.src o_sync
);
    logic [3:0] st1_ff;
    logic [3:0] st2_ff;
    logic [3:0] st3_ff;
    logic [3:0] val_ff;

    // ****************************************
    // Per-line chains
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_line
            // Agreement filter rejects a single metastable sample
            always_ff @(posedge i_clk) begin
                if (i_rst) begin
                    st1_ff[g] <= 1'b0;
                    st2_ff[g] <= 1'b0;
                    st3_ff[g] <= 1'b0;
                    val_ff[g] <= 1'b0;
                end else if (i_ce) begin
                    st1_ff[g] <= i_raw[g];
                    st2_ff[g] <= st1_ff[g];
                    st3_ff[g] <= st2_ff[g];
                    if (st2_ff[g] == st3_ff[g]) begin
                        val_ff[g] <= st3_ff[g];
                    end
                end
            end
        end
    endgenerate

    assign o_sync.dma_req = val_ff[0];
    assign o_sync.sack = val_ff[1];
    assign o_sync.halt = val_ff[2];
    assign o_sync.pwr_ok = val_ff[3];
endmodule // bdh_in_sync
`default_nettype wire

// ==== rtl/bdh_ctrl.sv ====
// Processor-side backplane control: DMA arbitration, halt detect, power-fail, ext address.
// Assumes backplane pins are asynchronous; core signals are on i_clk.
`default_nettype none
module bdh_ctrl (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_dma_bus_request_n,
    input wire logic i_select_acknowledge_n,
    input wire logic i_halt_request_n,
    input wire logic i_ac_power_good,
    input wire logic i_cpu_cycle_busy,
    input wire logic i_cpu_drives_sync,
    input wire logic i_addr_phase,
    input wire logic [21:0] i_cpu_addr,
    input wire logic i_ext_irq,
    output logic o_dma_grant_out_n,
    output logic o_cpu_may_master,
    output logic o_halted,
    output logic o_halt_irq,
    output logic o_debug_microcode,
    output logic o_irq_accept,
    output logic o_power_fail_trap,
    output logic [3:0] o_ext_addr_n,
    output logic o_ext_addr_oe
);
    bdh_sync_if sync_bus ();
    bdh_pkg::bdh_arb_t arb_ff;
    bdh_pkg::bdh_arb_t nxt_arb;
    logic [bdh_pkg::HALT_CNT_W-1:0] halt_cnt_ff;
    logic halted_ff;
    logic halt_irq_ff;
    logic grant_ff;
    logic may_ff;
    logic irq_ff;
    logic pf_ff;
    logic pok_prev_ff;
    logic [3:0] ext_ff;
    logic ext_oe_ff;

    // ****************************************
    // Input synchronisers
    // ****************************************
    // Lines inverted so the core sees active-high levels
    bdh_in_sync u_sync (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_ce (i_ce),
        .i_raw ({i_ac_power_good, ~i_halt_request_n, ~i_select_acknowledge_n,
                 ~i_dma_bus_request_n}),
        .o_sync (sync_bus.src)
    );

    // ****************************************
    // Arbiter
    // ****************************************
    // Next-state logic; request honoured also while halted
    always_comb begin
        nxt_arb = arb_ff;
        unique case (arb_ff)
            bdh_pkg::ARB_CPU: begin
                if (sync_bus.dma_req) begin
                    nxt_arb = bdh_pkg::ARB_WAIT; // RL6
                end
            end
            bdh_pkg::ARB_WAIT: begin
                // Grant only after our cycle ends and sync is released
                if (!i_cpu_cycle_busy && !i_cpu_drives_sync) begin
                    nxt_arb = bdh_pkg::ARB_GRANT; // RL2
                end
            end
            bdh_pkg::ARB_GRANT: begin
                if (sync_bus.sack) begin
                    nxt_arb = bdh_pkg::ARB_DMA; // RL4
                end else if (!sync_bus.dma_req) begin
                    nxt_arb = bdh_pkg::ARB_CPU; // Request vanished, no taker
                end
            end
            bdh_pkg::ARB_DMA: begin
                if (!sync_bus.sack) begin
                    nxt_arb = bdh_pkg::ARB_CPU; // RL4
                end
            end
            default: nxt_arb = bdh_pkg::ARB_CPU;
        endcase
    end

    // State register
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            arb_ff <= bdh_pkg::ARB_CPU;
        end else if (i_ce) begin
            arb_ff <= nxt_arb;
        end
    end

    // Grant and mastership outputs registered from next state
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            grant_ff <= 1'b0;
            may_ff <= 1'b1;
        end else if (i_ce) begin
            grant_ff <= (nxt_arb == bdh_pkg::ARB_GRANT); // RL2 RL4
            // Processor stays off the bus until acknowledge released
            may_ff <= (nxt_arb == bdh_pkg::ARB_CPU) || (nxt_arb == bdh_pkg::ARB_WAIT); // RL4
        end
    end

    // ****************************************
    // Halt detect
    // ****************************************
    // Counter restarts on any gap, so only a continuous hold qualifies
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            halt_cnt_ff <= '0;
            halted_ff <= 1'b0;
            halt_irq_ff <= 1'b0;
        end else if (i_ce) begin
            halt_irq_ff <= 1'b0;
            if (!sync_bus.halt) begin
                halt_cnt_ff <= '0;
                halted_ff <= 1'b0;
            end else if (halt_cnt_ff != bdh_pkg::HALT_CNT_W'(bdh_pkg::HALT_CYCLES)) begin
                halt_cnt_ff <= halt_cnt_ff + 1'b1; // RL5
                if (halt_cnt_ff == bdh_pkg::HALT_CNT_W'(bdh_pkg::HALT_CYCLES - 1)) begin
                    halted_ff <= 1'b1; // RL5
                    halt_irq_ff <= 1'b1; // RL5
                end
            end
        end
    end

    // Interrupt gating and debug microcode select while halted
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            irq_ff <= 1'b0;
        end else if (i_ce) begin
            irq_ff <= i_ext_irq && !halted_ff; // RL6
        end
    end

    // ****************************************
    // Power fail
    // ****************************************
    // Trap pulse on falling AC good while running; halted CPU does not trap
    // Previous value resets low like the filter, so leaving reset makes no false edge
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pok_prev_ff <= 1'b0;
            pf_ff <= 1'b0;
        end else if (i_ce) begin
            pok_prev_ff <= sync_bus.pwr_ok;
            pf_ff <= pok_prev_ff && !sync_bus.pwr_ok && !halted_ff; // RL9
        end
    end

    // ****************************************
    // Extended address lines
    // ****************************************
    // Driven only in our address phase; released otherwise
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ext_ff <= bdh_pkg::EXT_ADDR_RST;
            ext_oe_ff <= 1'b0;
        end else if (i_ce) begin
            ext_oe_ff <= i_addr_phase && may_ff; // RL10
            ext_ff <= i_addr_phase ? ~i_cpu_addr[bdh_pkg::EXT_ADDR_LO +: bdh_pkg::EXT_ADDR_W]
                                   : bdh_pkg::EXT_ADDR_RST; // RL10
        end
    end

    assign o_dma_grant_out_n = ~grant_ff;
    assign o_cpu_may_master = may_ff;
    assign o_halted = halted_ff;
    assign o_debug_microcode = halted_ff; // RL6
    assign o_halt_irq = halt_irq_ff;
    assign o_irq_accept = irq_ff;
    assign o_power_fail_trap = pf_ff;
    assign o_ext_addr_n = ext_ff;
    assign o_ext_addr_oe = ext_oe_ff;
endmodule // bdh_ctrl
`default_nettype wire

// ==== bench/bdh_ctrl_props.sv ====
// Port checker for bdh_ctrl, bound below.
// Assumes i_ce held high.
`default_nettype none
module bdh_ctrl_props (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_halt_request_n,
    input wire logic i_ac_power_good,
    input wire logic i_cpu_cycle_busy,
    input wire logic i_cpu_drives_sync,
    input wire logic i_addr_phase,
    input wire logic i_select_acknowledge_n,
    input wire logic o_dma_grant_out_n,
    input wire logic o_cpu_may_master,
    input wire logic o_halted,
    input wire logic o_halt_irq,
    input wire logic o_irq_accept,
    input wire logic o_power_fail_trap,
    input wire logic o_ext_addr_oe,
    input wire logic [21:0] i_cpu_addr,
    input wire logic [3:0] o_ext_addr_n
);
    timeunit 1ns / 1ns;
    int hcnt_ff;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // Halt pin low time; saturates so it never wraps
    always_ff @(posedge i_clk) hcnt_ff <= i_halt_request_n ? 0 : hcnt_ff + int'(hcnt_ff < 5000);
    property p_grant;
        $fell(o_dma_grant_out_n) |-> !$past(i_cpu_cycle_busy) && !$past(i_cpu_drives_sync);
    endproperty
    a_grant: assert property (p_grant) else $error("grant during cpu cycle");
    property p_resume; $rose(o_cpu_may_master) |-> $past(i_select_acknowledge_n, 4); endproperty
    a_resume: assert property (p_resume) else $error("cpu resumed under ack");
    property p_halt;
        $rose(o_halted) |-> o_halt_irq && hcnt_ff >= bdh_pkg::HALT_CYCLES;
    endproperty
    a_halt: assert property (p_halt) else $error("halt taken too soon");
    property p_mask; o_halted && $past(o_halted) |-> !o_irq_accept; endproperty
    a_mask: assert property (p_mask) else $error("irq taken while halted");
    property p_trap; $fell(i_ac_power_good) && !o_halted |-> ##[2:8] o_power_fail_trap; endproperty
    a_trap: assert property (p_trap) else $error("no power fail trap");
    // A trap with power still good would be a false edge, e.g. after reset
    property p_trap_cause; o_power_fail_trap |-> !$past(i_ac_power_good); endproperty
    a_trap_cause: assert property (p_trap_cause) else $error("trap without loss");
    // Lines stay released while a DMA device owns the bus
    property p_ext_own; o_ext_addr_oe |-> $past(o_cpu_may_master); endproperty
    a_ext_own: assert property (p_ext_own) else $error("ext lines driven as slave");
    property p_ext;
        o_ext_addr_oe |-> $past(i_addr_phase) && o_ext_addr_n == ~$past(i_cpu_addr[21:18]);
    endproperty
    a_ext: assert property (p_ext) else $error("bad extended address");
    c_grant: cover property ($fell(o_dma_grant_out_n));
    c_halt: cover property ($rose(o_halted));
    c_trap: cover property (o_power_fail_trap);
    c_resume: cover property ($rose(o_cpu_may_master));
endmodule // bdh_ctrl_props
bind bdh_ctrl bdh_ctrl_props u_props (.*);
`default_nettype wire

// ==== bench/bdh_dma_model.sv ====
// DMA option on the far side of the arbiter.
// Assumes i_go pulses one cycle; released lines float high.
`default_nettype none
module bdh_dma_model (
    input wire logic i_clk,
    input wire logic i_go,
    input wire logic [7:0] i_hold,
    input wire logic i_dma_grant_out_n,
    output var logic o_dma_bus_request_n = 1'h1,
    output var logic o_select_acknowledge_n = 1'h1
);
    timeunit 1ns / 1ns;
    logic [7:0] left_ff = 8'h00;
    // Request holds until granted, then turns into a timed acknowledge
    always @(posedge i_clk) begin
        if (i_go) o_dma_bus_request_n <= 1'h0;
        // Tenure runs no sync/data-in transfers, so the refresh line stays released
        if (!i_dma_grant_out_n && !o_dma_bus_request_n) begin
            o_dma_bus_request_n <= 1'h1;
            o_select_acknowledge_n <= 1'h0;
            // Tenure of at most 256 cycles (i_hold plus one), far inside the refresh interval
            left_ff <= i_hold;
        end else if (left_ff != 8'h00) left_ff <= left_ff - 8'h01;
        else o_select_acknowledge_n <= 1'h1;
    end
endmodule // bdh_dma_model
`default_nettype wire

// ==== bench/backplane_dma_halt_control_tb.sv ====
// Self-checking bench for bdh_ctrl with a DMA option model.
// Assumes package, interface, checker and model compiled first.
`default_nettype none
module backplane_dma_halt_control_tb;
    timeunit 1ns / 1ns;
    logic i_clk = 1'h0, i_rst = 1'h1, busy = 1'h0, dsync = 1'h0, aph = 1'h0, irq = 1'h0;
    logic halt_n = 1'h1, pg = 1'h1, go = 1'h0, req_n, sack_n, gnt_n, may, hlt, hirq, iacc, trap, oe;
    logic dbg;
    logic [7:0] hold = 8'h08;
    logic [21:0] addr = 22'h00_0000;
    logic [3:0] ext_n;
    int failures = 0, samples_checked = 0, cyc = 0;
    // 50 MHz clock
    always #10 i_clk = ~i_clk;
    bdh_ctrl DUT (.i_clk(i_clk), .i_rst(i_rst), .i_ce(1'h1), .i_dma_bus_request_n(req_n),
        .i_select_acknowledge_n(sack_n), .i_halt_request_n(halt_n), .i_ac_power_good(pg),
        .i_cpu_cycle_busy(busy), .i_cpu_drives_sync(dsync), .i_addr_phase(aph),
        .i_cpu_addr(addr), .i_ext_irq(irq), .o_dma_grant_out_n(gnt_n), .o_cpu_may_master(may),
        .o_halted(hlt), .o_halt_irq(hirq), .o_debug_microcode(dbg), .o_irq_accept(iacc),
        .o_power_fail_trap(trap), .o_ext_addr_n(ext_n), .o_ext_addr_oe(oe));
    bdh_dma_model u_dma (.i_clk(i_clk), .i_go(go), .i_hold(hold), .i_dma_grant_out_n(gnt_n),
        .o_dma_bus_request_n(req_n), .o_select_acknowledge_n(sack_n));
    function automatic logic [3:0] exp_ext(input logic [21:0] a, input logic p);
        return p ? ~a[21:18] : 4'h0;
    endfunction
    task automatic chk(input string nm, input logic [21:0] seen, input logic [21:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cy(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    // Bounded wait, sampled mid-cycle where outputs are settled
    task automatic wt(ref logic s, input logic v);
        for (int k = 0; k < 100 && s !== v; k++) @(negedge i_clk);
    endtask
    task automatic end_of_test;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // One grant; b picks whether a cycle or the sync line holds it off
    task automatic dma(input logic b);
        @(posedge i_clk);
        busy <= b;
        dsync <= !b;
        aph <= 1'h1;
        hold <= 8'($urandom_range(8, 40));
        go <= 1'h1;
        @(posedge i_clk);
        go <= 1'h0;
        cy($urandom_range(6, 30));
        chk("grant_early", gnt_n, 1'h1);
        @(posedge i_clk);
        busy <= 1'h0;
        dsync <= 1'h0;
        wt(gnt_n, 1'h0);
        chk("grant", {gnt_n, may}, 2'h0);
        wt(gnt_n, 1'h1);
        chk("ack_hold", {sack_n, may}, 2'h0);
        chk("ext_dma", oe, 1'h0);
        wt(may, 1'h1);
        chk("ack_free", sack_n, 1'h1);
    endtask
    // Hang guard well above the expected run length
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 12000) begin
            failures++;
            end_of_test();
        end
    end
    initial begin
        void'($urandom(13));
        cy(3);
        @(posedge i_clk);
        i_rst <= 1'h0;
        cy(1);
        chk("reset", {gnt_n, may, hlt, oe, dbg}, 5'h18);
        cy(2);
        chk("reset_trap", trap, 1'h0);
        $display("reset test done");
        for (int i = 0; i < 4; i++) dma(i[0]);
        $display("dma test done");
        for (int i = 0; i < 8; i++) begin
            @(posedge i_clk);
            aph <= i[0];
            addr <= (i == 1) ? 22'h3C_0000 : 22'($urandom);
            cy(2);
            chk("ext_oe", oe, aph);
            chk("ext_addr", ext_n, exp_ext(addr, aph));
        end
        $display("address test done");
        @(posedge i_clk);
        halt_n <= 1'h0;
        irq <= 1'h1;
        cy(1240);
        @(posedge i_clk);
        halt_n <= 1'h1;
        cy(8);
        chk("halt_short", hlt, 1'h0);
        @(posedge i_clk);
        halt_n <= 1'h0;
        cy(1240);
        chk("halt_early", hlt, 1'h0);
        wt(hlt, 1'h1);
        chk("halt", {hlt, hirq}, 2'h3);
        chk("debug_on", dbg, 1'h1);
        dma(1'h0);
        chk("halted", {hlt, iacc, dbg}, 3'h5);
        @(posedge i_clk);
        halt_n <= 1'h1;
        wt(hlt, 1'h0);
        chk("debug_off", dbg, 1'h0);
        cy(2);
        chk("irq_open", iacc, 1'h1);
        $display("halt test done");
        @(posedge i_clk);
        pg <= 1'h0;
        wt(trap, 1'h1);
        chk("trap", trap, 1'h1);
        cy(1);
        chk("trap_pulse", trap, 1'h0);
        $display("power test done");
        end_of_test();
    end
endmodule // backplane_dma_halt_control_tb
`default_nettype wire
